// >>> include/tltc_consts.vh
// Constants for the line trigger and scan direction controller.
// Assumes a 125 MHz clock and a 32-bit APB register port.
//
// Overview of operation
// - Internal origin fires lines from a timer at the programmed period.
// - External trigger fires on rising, falling or both edges as selected.
// - Triggers arriving faster than the mode limit are dropped.
// - Normal one line per trigger resumes by itself once rate falls.
// - Mode limits: SR 200 kHz, TDI 400 kHz, area 2 kHz, extended 650 Hz.
// - Rates below 10 kHz are accepted and acquisition continues.
// - Accepted line rate is measured; refresh command updates the readable value.
// - Internal direction source uses the stored direction setting.
// - Input line two direction source follows that line's level.
// - Encoder direction only with encoder trigger and motion output mode.
// - Direction changes take effect in well under 1 ms.
// - Integration equals line period times number of stages in the mode.
// - Row spacing data for both arrays is supplied to the grabber.
// - Markers overlay the image with programmable pitch, shift and colour.
`ifndef TLTC_CONSTS_VH
`define TLTC_CONSTS_VH

// ==========================================================
// Timing
`define TLTC_CLK_HZ 125000000
`define TLTC_HZ_SR 200000
`define TLTC_HZ_TDI 400000
`define TLTC_HZ_AREA 2000
`define TLTC_HZ_XAREA 650
`define TLTC_HZ_MIN 10000
`define TLTC_CYC(hz) ((`TLTC_CLK_HZ + (hz) - 1) / (hz))
`define TLTC_METER_WINDOW_US 1000
`define TLTC_METER_CYC (`TLTC_CLK_HZ / 1000000 * `TLTC_METER_WINDOW_US)
`define TLTC_DIR_CHANGE_US 1000

// ==========================================================
// Register offsets
`define TLTC_OFS_CTRL 8'h00
`define TLTC_OFS_PERIOD 8'h04
`define TLTC_OFS_MROW 8'h08
`define TLTC_OFS_MCOL 8'h0C
`define TLTC_OFS_CMD 8'h10
`define TLTC_OFS_RATE 8'h14
`define TLTC_OFS_STATUS 8'h18
`define TLTC_OFS_SPACE 8'h1C
`define TLTC_OFS_INTEG 8'h20

// ==========================================================
// Control fields
`define TLTC_F_ORIGIN 0
`define TLTC_F_SRC 1
`define TLTC_F_EDGE 3
`define TLTC_F_DIRSRC 5
`define TLTC_F_DIR 7
`define TLTC_F_ENCMODE 8
`define TLTC_F_MARK 9
`define TLTC_F_DARK 10
`define TLTC_F_MODE 11
`define TLTC_F_REFRESH 0
`define TLTC_F_DROPCLR 1

// ==========================================================
// Encodings
`define TLTC_SRC_LINE1 2'h0
`define TLTC_SRC_LINK 2'h1
`define TLTC_SRC_ENC 2'h2
`define TLTC_EDGE_RISE 2'h0
`define TLTC_EDGE_FALL 2'h1
`define TLTC_EDGE_ANY 2'h2
`define TLTC_DIR_INT 2'h0
`define TLTC_DIR_LINE2 2'h1
`define TLTC_DIR_ENC 2'h2
`define TLTC_MODE_TDI 3'h0
`define TLTC_MODE_SR 3'h1
`define TLTC_MODE_PLANAR 3'h2
`define TLTC_MODE_AREA 3'h3
`define TLTC_MODE_XAREA 3'h4

// ==========================================================
// Reset values and fixed data
`define TLTC_RST_CTRL 32'h0000_0000
`define TLTC_RST_PERIOD 32'h0000_30D4
`define TLTC_RST_MARKER 32'h0000_0040
`define TLTC_STAGES_MAIN 8'h80
`define TLTC_STAGES_EXT 8'hC0
`define TLTC_ROW_GAP_FWD 16'h0010
`define TLTC_ROW_GAP_REV 16'h0011

`endif

// >>> rtl/tltc_sync_edge.v
// Two-stage synchronisers with edge detection for the external pins.
// Assumes pins are static enough to be sampled at the core clock.
`timescale 1ns/10ps
`default_nettype none

module tltc_sync_edge (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Raw pins
    input wire [2:0] pin_raw,
    // Synchronised level and edges
    output wire [2:0] pin_level,
    output wire [2:0] pin_rise,
    output wire [2:0] pin_fall
);

// ==========================================================
// Per pin synchroniser
genvar i;
generate
    for (i = 0; i < 3; i = i + 1) begin : g_pin
        reg meta;
        reg stable;
        reg prev;
        always @(posedge clk) begin
            if (!rst_b) begin
                meta <= 1'b0;
                stable <= 1'b0;
                prev <= 1'b0;
            end else begin
                meta <= pin_raw[i];
                stable <= meta;
                prev <= stable;
            end
        end
        assign pin_level[i] = stable;
        assign pin_rise[i] = stable & ~prev;
        assign pin_fall[i] = ~stable & prev;
    end
endgenerate

endmodule // tltc_sync_edge

`default_nettype wire

// >>> rtl/tltc_rate_meter.v
// Counts accepted lines per fixed window; refresh copies the last window.
// Assumes one line pulse per cycle at most.
`timescale 1ns/10ps
`default_nettype none
`include "tltc_consts.vh"

module tltc_rate_meter #(
    parameter [31:0] WINDOW_CYC = `TLTC_METER_CYC
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Events
    input wire line_tick,
    input wire refresh,
    // Lines per window
    output reg [31:0] rate
);

reg [31:0] win_cnt;
reg [31:0] line_cnt;
reg [31:0] last_cnt;

// ==========================================================
// Window and count
always @(posedge clk) begin
    if (!rst_b) begin
        win_cnt <= 32'h0000_0000;
        line_cnt <= 32'h0000_0000;
        last_cnt <= 32'h0000_0000;
        rate <= 32'h0000_0000;
    end else begin
        if (win_cnt >= WINDOW_CYC - 32'h0000_0001) begin
            win_cnt <= 32'h0000_0000;
            last_cnt <= line_cnt + {31'h0000_0000, line_tick};
            line_cnt <= 32'h0000_0000;
        end else begin
            win_cnt <= win_cnt + 32'h0000_0001;
            line_cnt <= line_cnt + {31'h0000_0000, line_tick};
        end
        if (refresh) begin
            rate <= last_cnt;
        end
    end
end

endmodule // tltc_rate_meter

`default_nettype wire

// >>> rtl/tltc_top.v
// Line trigger, rate limit, scan direction and marker overlay controller.
// Assumes APB master on the core clock and pins synchronous-ready inputs.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "tltc_consts.vh"

module tltc_top #(
    parameter [31:0] AREA_MIN_CYC = `TLTC_CYC(`TLTC_HZ_AREA),
    parameter [31:0] XAREA_MIN_CYC = `TLTC_CYC(`TLTC_HZ_XAREA),
    parameter [31:0] METER_WINDOW_CYC = `TLTC_METER_CYC
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Trigger and direction pins
    input wire gpio_line1,
    input wire gpio_line2,
    input wire grabber_link_trigger,
    // Line and direction outputs
    output reg line_trigger,
    output reg scan_reverse,
    output reg [15:0] row_spacing,
    // Pixel stream
    input wire pix_valid,
    input wire pix_sol,
    input wire pix_sof,
    input wire [11:0] pix_data,
    output reg pix_out_valid,
    output reg [11:0] pix_out_data
);

localparam [31:0] SR_MIN_CYC = `TLTC_CYC(`TLTC_HZ_SR);
localparam [31:0] TDI_MIN_CYC = `TLTC_CYC(`TLTC_HZ_TDI);
localparam [31:0] ONE = 32'h0000_0001;

// ==========================================================
// Registers
reg [31:0] ctrl;
reg [31:0] internal_line_rate_value;
reg [31:0] mrow;
reg [31:0] mcol;
reg [15:0] drop_count;
reg [31:0] last_interval;
reg rate_measurement_update_cmd;

wire trigger_origin_select = ctrl[`TLTC_F_ORIGIN];
wire [1:0] external_trigger_input_select = ctrl[`TLTC_F_SRC +: 2];
wire [1:0] trigger_edge_select = ctrl[`TLTC_F_EDGE +: 2];
wire [1:0] direction_origin_select = ctrl[`TLTC_F_DIRSRC +: 2];
wire manual_travel_direction = ctrl[`TLTC_F_DIR];
wire encoder_output_behaviour = ctrl[`TLTC_F_ENCMODE];
wire marker_overlay_on = ctrl[`TLTC_F_MARK];
wire marker_dark_colour = ctrl[`TLTC_F_DARK];
wire [2:0] imaging_mode = ctrl[`TLTC_F_MODE +: 3];
wire [15:0] marker_row_pitch = mrow[15:0];
wire [15:0] marker_row_shift = mrow[31:16];
wire [15:0] marker_column_pitch = mcol[15:0];
wire [15:0] marker_column_shift = mcol[31:16];

// ==========================================================
// APB decode
wire apb_wr = psel & penable & pwrite;
wire apb_setup = psel & ~penable;
reg mapped;
reg [31:0] rd_val;
wire [31:0] observed_trigger_rate;
reg [7:0] stages;
wire [39:0] integ_full = last_interval * stages;

assign pready = 1'b1;
assign pslverr = psel & penable & ~mapped;

always @* begin
    mapped = (paddr[1:0] == 2'h0);
    rd_val = 32'h0000_0000;
    case (paddr)
        `TLTC_OFS_CTRL: rd_val = ctrl;
        `TLTC_OFS_PERIOD: rd_val = internal_line_rate_value;
        `TLTC_OFS_MROW: rd_val = mrow;
        `TLTC_OFS_MCOL: rd_val = mcol;
        `TLTC_OFS_CMD: rd_val = 32'h0000_0000;
        `TLTC_OFS_RATE: rd_val = observed_trigger_rate;
        `TLTC_OFS_STATUS: rd_val = {15'h0000, scan_reverse, drop_count};
        `TLTC_OFS_SPACE: rd_val = {`TLTC_ROW_GAP_REV, `TLTC_ROW_GAP_FWD};
        `TLTC_OFS_INTEG: rd_val = integ_full[31:0];
        default: mapped = 1'b0;
    endcase
end

always @(posedge clk) begin
    if (!rst_b) begin
        prdata <= 32'h0000_0000;
        ctrl <= `TLTC_RST_CTRL;
        internal_line_rate_value <= `TLTC_RST_PERIOD;
        mrow <= `TLTC_RST_MARKER;
        mcol <= `TLTC_RST_MARKER;
        rate_measurement_update_cmd <= 1'b0;
    end else begin
        rate_measurement_update_cmd <= 1'b0;
        if (apb_setup) begin
            prdata <= rd_val;
        end
        if (apb_wr) begin
            case (paddr)
                `TLTC_OFS_CTRL: ctrl <= {18'h0_0000, pwdata[13:0]};
                `TLTC_OFS_PERIOD: internal_line_rate_value <= pwdata;
                `TLTC_OFS_MROW: mrow <= pwdata;
                `TLTC_OFS_MCOL: mcol <= pwdata;
                `TLTC_OFS_CMD: rate_measurement_update_cmd <= pwdata[`TLTC_F_REFRESH];
                default: ;
            endcase
        end
    end
end

wire drop_clear = apb_wr & (paddr == `TLTC_OFS_CMD) & pwdata[`TLTC_F_DROPCLR];

// ==========================================================
// Pin synchronisers
wire [2:0] pin_level;
wire [2:0] pin_rise;
wire [2:0] pin_fall;

tltc_sync_edge u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_raw({grabber_link_trigger, gpio_line2, gpio_line1}),
    .pin_level(pin_level),
    .pin_rise(pin_rise),
    .pin_fall(pin_fall)
);

// ==========================================================
// Internal line timer
reg [31:0] int_cnt;
reg int_pulse;

always @(posedge clk) begin
    if (!rst_b) begin
        int_cnt <= 32'h0000_0000;
        int_pulse <= 1'b0;
    end else if (!trigger_origin_select) begin
        int_pulse <= 1'b0;
        if (int_cnt + ONE >= internal_line_rate_value) begin
            int_cnt <= 32'h0000_0000;
            int_pulse <= 1'b1;
        end else begin
            int_cnt <= int_cnt + ONE;
        end
    end else begin
        int_cnt <= 32'h0000_0000;
        int_pulse <= 1'b0;
    end
end

// ==========================================================
// External source and edge select
reg src_rise;
reg src_fall;
reg ext_hit;

always @* begin
    src_rise = 1'b0;
    src_fall = 1'b0;
    case (external_trigger_input_select)
        `TLTC_SRC_LINE1: begin
            src_rise = pin_rise[0];
            src_fall = pin_fall[0];
        end
        `TLTC_SRC_LINK: begin
            src_rise = pin_rise[2];
            src_fall = pin_fall[2];
        end
        `TLTC_SRC_ENC: begin
            src_rise = pin_rise[0];
            src_fall = pin_fall[0];
        end
        default: ;
    endcase
    case (trigger_edge_select)
        `TLTC_EDGE_RISE: ext_hit = src_rise;
        `TLTC_EDGE_FALL: ext_hit = src_fall;
        `TLTC_EDGE_ANY: ext_hit = src_rise | src_fall;
        default: ext_hit = 1'b0;
    endcase
end

wire cand = trigger_origin_select ? ext_hit : int_pulse;

// ==========================================================
// Rate limiter
reg [31:0] min_cyc;
reg [31:0] since_cnt;

always @* begin
    case (imaging_mode)
        `TLTC_MODE_SR: min_cyc = SR_MIN_CYC;
        `TLTC_MODE_AREA: min_cyc = AREA_MIN_CYC;
        `TLTC_MODE_XAREA: min_cyc = XAREA_MIN_CYC;
        default: min_cyc = TDI_MIN_CYC;
    endcase
    case (imaging_mode)
        `TLTC_MODE_XAREA: stages = `TLTC_STAGES_EXT;
        default: stages = `TLTC_STAGES_MAIN;
    endcase
end

wire accept = cand & (since_cnt + ONE >= min_cyc);
wire drop = cand & ~accept;

always @(posedge clk) begin
    if (!rst_b) begin
        since_cnt <= 32'hFFFF_FFFE;
        last_interval <= 32'h0000_0000;
        line_trigger <= 1'b0;
        drop_count <= 16'h0000;
    end else begin
        line_trigger <= accept;
        if (accept) begin
            since_cnt <= 32'h0000_0000;
            last_interval <= since_cnt + ONE;
        end else if (since_cnt != 32'hFFFF_FFFE) begin
            since_cnt <= since_cnt + ONE;
        end
        if (drop_clear) begin
            drop_count <= {15'h0000, drop};
        end else if (drop && drop_count != 16'hFFFF) begin
            drop_count <= drop_count + 16'h0001;
        end
    end
end

// ==========================================================
// Rate measurement
tltc_rate_meter #(
    .WINDOW_CYC(METER_WINDOW_CYC)
) u_meter (
    .clk(clk),
    .rst_b(rst_b),
    .line_tick(line_trigger),
    .refresh(rate_measurement_update_cmd),
    .rate(observed_trigger_rate)
);

// ==========================================================
// Scan direction
reg enc_reverse;
wire enc_dir_ok = trigger_origin_select & encoder_output_behaviour &
    (external_trigger_input_select == `TLTC_SRC_ENC);
reg next_reverse;

always @* begin
    case (direction_origin_select)
        `TLTC_DIR_INT: next_reverse = manual_travel_direction;
        `TLTC_DIR_LINE2: next_reverse = pin_level[1];
        `TLTC_DIR_ENC: next_reverse = enc_dir_ok ? enc_reverse : manual_travel_direction;
        default: next_reverse = manual_travel_direction;
    endcase
end

always @(posedge clk) begin
    if (!rst_b) begin
        enc_reverse <= 1'b0;
        scan_reverse <= 1'b0;
        row_spacing <= `TLTC_ROW_GAP_FWD;
    end else begin
        if (pin_rise[0]) begin
            enc_reverse <= pin_level[1];
        end
        scan_reverse <= next_reverse;
        row_spacing <= next_reverse ? `TLTC_ROW_GAP_REV : `TLTC_ROW_GAP_FWD;
    end
end

// ==========================================================
// Alignment marker overlay
reg [15:0] col_ph;
reg [15:0] row_ph;
reg [15:0] col_now;
reg [15:0] row_now;

always @* begin
    col_now = pix_sol ? marker_column_shift : col_ph;
    row_now = row_ph;
    if (pix_sol) begin
        if (pix_sof) begin
            row_now = marker_row_shift;
        end else if (row_ph == 16'h0000) begin
            row_now = marker_row_pitch - 16'h0001;
        end else begin
            row_now = row_ph - 16'h0001;
        end
    end
end

wire mark_hit = marker_overlay_on & ((col_now == 16'h0000) | (row_now == 16'h0000));

always @(posedge clk) begin
    if (!rst_b) begin
        col_ph <= 16'h0000;
        row_ph <= 16'h0000;
        pix_out_valid <= 1'b0;
        pix_out_data <= 12'h000;
    end else begin
        pix_out_valid <= pix_valid;
        if (pix_valid) begin
            row_ph <= row_now;
            col_ph <= (col_now == 16'h0000) ? marker_column_pitch - 16'h0001 :
                col_now - 16'h0001;
            if (mark_hit) begin
                pix_out_data <= marker_dark_colour ? 12'h000 : 12'hFFF;
            end else begin
                pix_out_data <= pix_data;
            end
        end
    end
end

endmodule // tltc_top

`default_nettype wire

// >>> tb/tltc_top_properties.sv
// Checker: port-level properties of the line trigger controller.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

// ====
// Properties
module tltc_top_properties #(
    parameter [31:0] AREA_MIN_CYC = 32'h0000_F424,
    parameter [31:0] XAREA_MIN_CYC = 32'h0002_EF34,
    parameter [31:0] METER_WINDOW_CYC = 32'h0001_E848
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and outputs
    input wire logic gpio_line1,
    input wire logic gpio_line2,
    input wire logic line_trigger,
    input wire logic scan_reverse,
    input wire logic [15:0] row_spacing,
    // Pixels
    input wire logic pix_valid,
    input wire logic [11:0] pix_data,
    input wire logic pix_out_valid,
    input wire logic [11:0] pix_out_data
);
    logic [13:0] ctrl;
    logic [19:0] since;
    wire manual_sel = ctrl[6:5] == 2'h0 ||
        (ctrl[6:5] == 2'h2 && !(ctrl[0] && ctrl[2:1] == 2'h2 && ctrl[8]));

    // Shadow of the control word and cycles since the last line
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl <= 14'h0;
            since <= 20'hF_FFFF;
        end else begin
            if (psel && penable && pwrite && paddr == 8'h00)
                ctrl <= pwdata[13:0];
            if (line_trigger)
                since <= 20'h0;
            else if (since != 20'hF_FFFF)
                since <= since + 20'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_ready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (psel && penable && (paddr[1:0] != 2'h0 || paddr > 8'h20)
        |-> pslverr) else $error("no error on unmapped access");
    a_trig_pulse: assert property (line_trigger |=> !line_trigger)
        else $error("line pulse longer than one cycle");
    a_trig_spacing: assert property (line_trigger && since != 20'hF_FFFF |-> since >= 311)
        else $error("lines closer than the fastest mode allows");
    a_edge_fire: assert property (ctrl[2:0] == 3'h1 && ctrl[13:11] == 3'h0 && since > 330 &&
        (ctrl[4:3] == 2'h0 ? $rose(gpio_line1) : ctrl[4:3] == 2'h1 ? $fell(gpio_line1) :
        ctrl[4:3] == 2'h2 && $changed(gpio_line1)) |-> ##[1:6] line_trigger)
        else $error("selected edge gave no line");
    a_dir_manual: assert property ((manual_sel && $stable(ctrl)) [*3]
        |-> scan_reverse == ctrl[7]) else $error("direction differs from setting");
    a_dir_line2: assert property ((ctrl[6:5] == 2'h1 && $stable(ctrl) && $stable(gpio_line2)) [*5]
        |-> scan_reverse == gpio_line2) else $error("direction differs from line two");
    a_spacing_dir: assert property ($stable(scan_reverse) [*2]
        |-> row_spacing == (scan_reverse ? 16'h0011 : 16'h0010)) else $error("row gap wrong");
    a_pix_delay: assert property (1'b1 |=> pix_out_valid == $past(pix_valid))
        else $error("pixel strobe delay wrong");
    a_pix_pass: assert property (pix_valid && !ctrl[9] |=> pix_out_data == $past(pix_data))
        else $error("pixel altered with markers off");
    a_mark_colour: assert property (pix_valid && ctrl[9] |=> pix_out_data == $past(pix_data) ||
        pix_out_data == (ctrl[10] ? 12'h000 : 12'hFFF)) else $error("marker colour wrong");
endmodule // tltc_top_properties

bind tltc_top tltc_top_properties #(.AREA_MIN_CYC(AREA_MIN_CYC),
    .XAREA_MIN_CYC(XAREA_MIN_CYC), .METER_WINDOW_CYC(METER_WINDOW_CYC)) u_tltc_top_properties (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .gpio_line1(gpio_line1),
    .gpio_line2(gpio_line2), .line_trigger(line_trigger), .scan_reverse(scan_reverse),
    .row_spacing(row_spacing), .pix_valid(pix_valid), .pix_data(pix_data),
    .pix_out_valid(pix_out_valid), .pix_out_data(pix_out_data));

`default_nettype wire

// >>> tb/tltc_src_model.sv
// Model of the trigger source, encoder and link trigger feeding the pins.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none

// ====
// Source model
module tltc_src_model (
    // Clock
    input wire logic clk,
    // Pins toward the controller
    output logic line1,
    output logic line2,
    output logic link
);
    initial begin
        line1 = 1'b0;
        line2 = 1'b0;
        link = 1'b0;
    end

    // Pulse train on line one or the link; half period set by the caller
    task automatic pulses(input int pin, input int n, input int half);
        for (int i = 0; i < n; i++) begin
            repeat (half) @(posedge clk);
            if (pin == 0) line1 <= 1'b1; else link <= 1'b1;
            repeat (half) @(posedge clk);
            if (pin == 0) line1 <= 1'b0; else link <= 1'b0;
        end
    endtask

    task automatic set_l2(input logic v);
        line2 <= v;
    endtask

    // Quadrature steps, one line-one rise every 316 cycles
    task automatic enc(input logic rev, input int n);
        for (int i = 0; i < n; i++) begin
            repeat (79) @(posedge clk);
            if (rev) line2 <= 1'b1; else line1 <= 1'b1;
            repeat (79) @(posedge clk);
            if (rev) line1 <= 1'b1; else line2 <= 1'b1;
            repeat (79) @(posedge clk);
            if (rev) line2 <= 1'b0; else line1 <= 1'b0;
            repeat (79) @(posedge clk);
            if (rev) line1 <= 1'b0; else line2 <= 1'b0;
        end
    endtask
endmodule // tltc_src_model

`default_nettype wire

// >>> tb/tltc_top_tb.sv
// Testbench: APB and pin sequences for the line trigger controller.
// Assumes the source model and the checker bind are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "tltc_consts.vh"

// ====
// Bench
module tltc_top_tb;
    logic clk, rst_b, psel, penable, pwrite, pix_valid, pix_sol, pix_sof, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, rv;
    logic [11:0] pix_data;
    wire l1, l2, lk, pready, pslverr, line_trigger, scan_reverse, pov;
    wire [31:0] prdata;
    wire [15:0] row_spacing;
    wire [11:0] pod;
    int bad_count = 0, n_compared = 0, n_trig = 0, t_now = 0, t_last = 0, gap = 0, n0;
    int mg[5] = '{313, 625, 313, 1000, 2000};
    int xp[5] = '{0, 0, 0, 0, 1}, xn[5] = '{3, 3, 6, 0, 3};
    logic [1:0] xs[5] = '{0, 0, 0, 1, 1}, xe[5] = '{0, 1, 2, 0, 0};
    logic [7:0] ra[7] = '{`TLTC_OFS_CTRL, `TLTC_OFS_PERIOD, `TLTC_OFS_MROW, `TLTC_OFS_MCOL,
        `TLTC_OFS_RATE, `TLTC_OFS_STATUS, `TLTC_OFS_SPACE};
    logic [31:0] rr[7] = '{`TLTC_RST_CTRL, `TLTC_RST_PERIOD, `TLTC_RST_MARKER, `TLTC_RST_MARKER,
        32'h0, 32'h0, {`TLTC_ROW_GAP_REV, `TLTC_ROW_GAP_FWD}};

    tltc_top #(.AREA_MIN_CYC(32'h0000_03E8), .XAREA_MIN_CYC(32'h0000_07D0),
        .METER_WINDOW_CYC(32'h0000_0BB8)) u_tltc_top (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gpio_line1(l1), .gpio_line2(l2), .grabber_link_trigger(lk),
        .line_trigger(line_trigger), .scan_reverse(scan_reverse), .row_spacing(row_spacing),
        .pix_valid(pix_valid), .pix_sol(pix_sol), .pix_sof(pix_sof), .pix_data(pix_data),
        .pix_out_valid(pov), .pix_out_data(pod));
    tltc_src_model u_tltc_src_model (.clk(clk), .line1(l1), .line2(l2), .link(lk));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Line counter and spacing of the last two lines
    always @(posedge clk) begin
        t_now <= t_now + 1;
        if (line_trigger === 1'b1) begin
            n_trig <= n_trig + 1;
            gap <= t_now - t_last;
            t_last <= t_now;
        end
    end

    task automatic conclude();
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; returns read data in rv and the error flag in err
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin
            check("pready wait", 0, 1);
            conclude();
        end
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_trig(input int n, input int lim);
        int base;
        base = n_trig;
        while (n_trig < base + n && lim > 0) begin
            @(posedge clk);
            lim--;
        end
        if (lim == 0) begin
            check("line wait", 0, 1);
            conclude();
        end
    endtask

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pix_valid = 1'b0;
        pix_sol = 1'b0;
        pix_sof = 1'b0;
        pix_data = 12'h000;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 7; k++) begin
            apb(1'b0, ra[k], 32'h0);
            check("reset value", rv, rr[k]);
        end
        apb(1'b0, 8'h24, 32'h0);
        check("unmapped error", {err, rv[30:0]}, 32'h8000_0000);
        // Limiter in every mode with an every-cycle internal timer
        apb(1'b1, `TLTC_OFS_PERIOD, 32'h1);
        for (int m = 0; m < 5; m++) begin
            apb(1'b1, `TLTC_OFS_CTRL, m << `TLTC_F_MODE);
            wait_trig(3, 20000);
            check("mode gap", gap >= mg[m] - 1 && gap <= mg[m], 1'b1);
        end
        apb(1'b1, `TLTC_OFS_CTRL, 32'h0);
        apb(1'b1, `TLTC_OFS_PERIOD, 32'h0000_01F4);
        wait_trig(3, 5000);
        check("internal gap", gap, 500);
        repeat (5000) @(posedge clk);
        apb(1'b1, `TLTC_OFS_CMD, 32'h1);
        repeat (3) @(posedge clk);
        apb(1'b0, `TLTC_OFS_RATE, 32'h0);
        check("measured rate", rv, 6);
        apb(1'b1, `TLTC_OFS_PERIOD, 32'h0000_3138);
        wait_trig(2, 30000);
        check("slow gap", gap, 12600);
        apb(1'b0, `TLTC_OFS_INTEG, 32'h0);
        check("integration", rv, 12600 * `TLTC_STAGES_MAIN);
        // External sources and edges
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, `TLTC_OFS_CTRL, {27'h0, xe[k], xs[k], 1'b1});
            n0 = n_trig;
            u_tltc_src_model.pulses(xp[k], 3, 400);
            repeat (10) @(posedge clk);
            check("external lines", n_trig - n0, xn[k]);
        end
        apb(1'b1, `TLTC_OFS_CTRL, 32'h1);
        apb(1'b1, `TLTC_OFS_CMD, 32'h2);
        n0 = n_trig;
        u_tltc_src_model.pulses(0, 10, 50);
        repeat (10) @(posedge clk);
        apb(1'b0, `TLTC_OFS_STATUS, 32'h0);
        check("accepted lines", n_trig - n0, 3);
        check("dropped lines", rv[15:0], 7);
        // Scan direction sources
        apb(1'b1, `TLTC_OFS_CTRL, 32'h0000_0080);
        apb(1'b0, `TLTC_OFS_STATUS, 32'h0);
        check("manual reverse", {rv[16], scan_reverse, row_spacing}, 32'h0003_0011);
        apb(1'b1, `TLTC_OFS_CTRL, 32'h0000_0020);
        for (int v = 1; v >= 0; v--) begin
            u_tltc_src_model.set_l2(v[0]);
            repeat (6) @(posedge clk);
            check("line two direction", scan_reverse, v[0]);
        end
        apb(1'b1, `TLTC_OFS_CTRL, 32'h0000_0145);
        u_tltc_src_model.enc(1'b0, 128);
        check("encoder forward", scan_reverse, 1'b0);
        u_tltc_src_model.enc(1'b1, 4);
        check("encoder reverse", scan_reverse, 1'b1);
        apb(1'b1, `TLTC_OFS_CTRL, 32'h0000_0045);
        repeat (3) @(posedge clk);
        check("encoder without motion", scan_reverse, 1'b0);
        // Marker overlay, light then dark
        apb(1'b1, `TLTC_OFS_MROW, 32'h0001_0040);
        apb(1'b1, `TLTC_OFS_MCOL, 32'h0001_0004);
        for (int d = 0; d < 2; d++) begin
            apb(1'b1, `TLTC_OFS_CTRL, d ? 32'h0000_0600 : 32'h0000_0200);
            for (int i = 0; i <= 8; i++) begin
                pix_valid <= (i < 8);
                pix_sol <= (i == 0);
                pix_sof <= (i == 0);
                pix_data <= 12'h123;
                @(posedge clk);
                if (i > 0)
                    check("marker pixel", pod, (i - 1) % 4 == 1 ? (d ? 0 : 12'hFFF) : 12'h123);
            end
        end
        conclude();
    end
endmodule // tltc_top_tb

`default_nettype wire
